/* controller_status_param_regs.sv */
// Purpose: holding-register bank for valve timing, output limits, failure output and status
// Assumes: frame decoding lives upstream; one word access per strobe
// Notes:   a refused write leaves the register unchanged and answers with an exception code
module controller_status_param_regs
   import ctl_regs_pkg::*;
#(
   parameter int unsigned MEAN_TICK_CYCLES = MEAN_CYCLES,
   parameter bit          HAS_DIG_INPUT    = 1'b1
) (
   input  wire logic             sys_clk,          // 10 MHz system clock
   input  wire logic             rst_n,            // asynchronous reset, active low
   input  wire logic             reg_wr,           // one-cycle write strobe
   input  wire logic             reg_rd,           // one-cycle read strobe
   input  wire logic [15:0]      reg_addr,         // holding-register address
   input  wire logic [15:0]      reg_wdata,        // write word
   output logic      [15:0]      reg_rdata,        // read word
   output logic                  reg_done,         // answer pulse
   output logic      [7:0]       reg_exc,          // exception code, zero when accepted
   input  wire ctl_status_t      status_in,        // controller state flags
   input  wire alarm_io_t        alarm_in,         // alarm and output states
   input  wire logic [15:0]      error_causes,     // per-cause controller error flags
   input  wire logic             dig_in_pin,       // digital input 1 pin, high when closed
   input  wire logic [15:0]      y_demand,         // control signal from the algorithm
   input  wire logic             onoff_mode,       // on-off control selected
   input  wire logic             sensor_fail,      // main sensor failure
   input  wire logic             program_stop,     // program control stopped
   input  wire logic [15:0]      fail_fixed_value, // fixed failure output value
   input  wire logic [16:0]      deviation_abs,    // magnitude of system deviation
   input  wire logic             aux_error,        // auxiliary input error
   input  wire valve_cmd_t       valve_demand,     // valve command from the algorithm
   output logic      [15:0]      y_out,            // final control signal
   output valve_cmd_t            valve_cmd,        // final valve command
   output logic      [15:0]      mean_value,       // tracked mean control value
   output logic      [15:0]      valve_open_time,  // open travel time
   output logic      [15:0]      valve_close_time, // close travel time
   output logic      [15:0]      min_valve_work_time // minimum valve pulse
);

   function automatic logic in_range(input logic [15:0] v, input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (v >= lo) && (v <= hi);
   endfunction : in_range

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi);
      logic [15:0] t;
      t = (v < lo) ? lo : v;
      clamp = (t > hi) ? hi : t;
   endfunction : clamp

   // reset release
   logic rst_meta_q;
   logic rst_sync_n;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_q <= 1'b0;
         rst_sync_n <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_n <= rst_meta_q;
      end
   end

   // digital input pin synchroniser
   logic dig_meta_q;
   logic dig_sync_q;
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         dig_meta_q <= 1'b0;
         dig_sync_q <= 1'b0;
      end else begin
         dig_meta_q <= dig_in_pin;
         dig_sync_q <= dig_meta_q;
      end
   end

   // parameter registers
   logic [15:0] open_t_q;
   logic [15:0] close_t_q;
   logic [15:0] min_work_q;
   logic [15:0] y_lo_q;
   logic [15:0] y_hi_q;
   logic [1:0]  aux_valve_q;
   logic [1:0]  fail_sel_q;
   logic [15:0] mean_hi_q;
   logic [15:0] max_dev_q;

   wire hit_status   = (reg_addr == ADDR_STATUS);
   wire hit_alarm    = (reg_addr == ADDR_ALARM);
   wire hit_error    = (reg_addr == ADDR_ERROR);
   wire hit_open     = (reg_addr == ADDR_OPEN_T);
   wire hit_close    = (reg_addr == ADDR_CLOSE_T);
   wire hit_work     = (reg_addr == ADDR_MIN_WORK);
   wire hit_lo       = (reg_addr == ADDR_Y_LO);
   wire hit_hi       = (reg_addr == ADDR_Y_HI);
   wire hit_aux      = (reg_addr == ADDR_AUX_VALVE);
   wire hit_fsel     = (reg_addr == ADDR_FAIL_SEL);
   wire hit_mhi      = (reg_addr == ADDR_MEAN_HI);
   wire hit_dev      = (reg_addr == ADDR_MAX_DEV);
   wire hit_ro       = hit_status | hit_alarm | hit_error;
   wire hit_rw       = hit_open | hit_close | hit_work | hit_lo | hit_hi | hit_aux
                       | hit_fsel | hit_mhi | hit_dev;

   wire travel_ok    = in_range(reg_wdata, TRAVEL_MIN, TRAVEL_MAX);            // [R1] [R2]
   wire work_ok      = in_range(reg_wdata, WORK_MIN, WORK_MAX);                // [R3]
   wire pct_ok       = in_range(reg_wdata, 16'h0000, PCT_MAX);                 // [R4] [R8]
   wire sel_ok       = in_range(reg_wdata, 16'h0000, SEL_MAX);                 // [R5] [R6]
   wire value_ok     = ((hit_open | hit_close) & travel_ok) | (hit_work & work_ok)
                       | ((hit_lo | hit_hi | hit_mhi) & pct_ok)
                       | ((hit_aux | hit_fsel) & sel_ok) | hit_dev;            // [R9]
   wire wr_ok        = reg_wr & hit_rw & value_ok;

   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         open_t_q    <= RST_OPEN_T;
         close_t_q   <= RST_CLOSE_T;
         min_work_q  <= RST_MIN_WORK;
         y_lo_q      <= RST_Y_LO;
         y_hi_q      <= RST_Y_HI;
         aux_valve_q <= RST_AUX_VALVE[1:0];
         fail_sel_q  <= RST_FAIL_SEL[1:0];
         mean_hi_q   <= RST_MEAN_HI;
         max_dev_q   <= RST_MAX_DEV;
      end else if (wr_ok) begin
         if (hit_open)  open_t_q    <= reg_wdata;                              // [R1]
         if (hit_close) close_t_q   <= reg_wdata;                              // [R2]
         if (hit_work)  min_work_q  <= reg_wdata;                              // [R3]
         if (hit_lo)    y_lo_q      <= reg_wdata;                              // [R4]
         if (hit_hi)    y_hi_q      <= reg_wdata;                              // [R4]
         if (hit_aux)   aux_valve_q <= reg_wdata[1:0];                         // [R5]
         if (hit_fsel)  fail_sel_q  <= reg_wdata[1:0];                         // [R6]
         if (hit_mhi)   mean_hi_q   <= reg_wdata;                              // [R8]
         if (hit_dev)   max_dev_q   <= reg_wdata;                              // [R9]
      end
   end

   // status words
   wire [15:0] err_word    = error_causes & ERROR_MASK;                        // [R23]
   wire [1:0]  main_dp     = status_in.sensor_input ? SENSOR_DP : status_in.main_dp; // [R11]
   wire [15:0] status_word = {
      |err_word, // [R19]
      status_in.aux_range_err, // [R18]
      status_in.main_range_err, // [R18]
      2'b00, // [R25]
      status_in.gain_set, // [R17]
      status_in.tune_active, // [R13]
      status_in.manual, // [R16]
      status_in.timer_done, // [R15]
      status_in.soft_start, // [R14]
      status_in.tune_failed, // [R13]
      status_in.aux_dp, // [R12]
      main_dp
   };
   wire        dig_state   = HAS_DIG_INPUT & dig_sync_q; // [R24]
   wire [15:0] alarm_word  = {
      5'b00000, // [R25]
      alarm_in.dig_out, // [R22]
      1'b0,
      dig_state, // [R22]
      alarm_in.output_short, // [R21]
      alarm_in.heater_burnout, // [R21]
      1'b0,
      alarm_in.alarm // [R20]
   };

   wire [15:0] rd_mux =
      hit_status ? status_word :
      hit_alarm  ? alarm_word  :
      hit_error  ? err_word    :
      hit_open   ? open_t_q    :
      hit_close  ? close_t_q   :
      hit_work   ? min_work_q  :
      hit_lo     ? y_lo_q      :
      hit_hi     ? y_hi_q      :
      hit_aux    ? {14'h0000, aux_valve_q} :
      hit_fsel   ? {14'h0000, fail_sel_q}  :
      hit_mhi    ? mean_hi_q   :
      hit_dev    ? max_dev_q   : 16'h0000;

   // writes to read-only words change nothing and report a bad address
   wire [7:0] exc_d =
      reg_wr ? (!hit_rw ? EXC_BAD_ADDR : (!value_ok ? EXC_BAD_VALUE : EXC_NONE)) :
      ((hit_ro | hit_rw) ? EXC_NONE : EXC_BAD_ADDR);                           // [R25]

   logic        done_q;
   logic [15:0] rdata_q;
   logic [7:0]  exc_q;
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         done_q  <= 1'b0;
         rdata_q <= 16'h0000;
         exc_q   <= EXC_NONE;
      end else begin
         done_q <= reg_wr | reg_rd;
         if (reg_wr | reg_rd) begin
            rdata_q <= reg_wr ? 16'h0000 : rd_mux;
            exc_q   <= exc_d;
         end
      end
   end

   // minute tick for mean tracking
   logic [31:0] tick_cnt_q;
   wire         minute_tick = (tick_cnt_q == 32'(MEAN_TICK_CYCLES - 1));
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         tick_cnt_q <= 32'h0000_0000;
      end else begin
         tick_cnt_q <= minute_tick ? 32'h0000_0000 : tick_cnt_q + 32'h0000_0001;
      end
   end

   // mean control value: halfway step toward the present output each minute with no failure or stop and deviation below the limit
   wire         fail_mode = sensor_fail | program_stop; // [R6]
   logic [15:0] mean_q;
   wire  [16:0] mean_sum = {1'b0, mean_q} + {1'b0, y_out};
   wire         track_ok = deviation_abs < {1'b0, max_dev_q};                  // [R7]
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         mean_q <= 16'h0000;
      end else if (minute_tick && track_ok && !fail_mode) begin
         mean_q <= mean_sum[16:1];                                             // [R7]
      end
   end

   // output path
   wire [15:0] mean_capped = (mean_q > mean_hi_q) ? mean_hi_q : mean_q;        // [R8]
   wire [15:0] fixed_fail = onoff_mode
                            ? ((fail_fixed_value <= PCT_HALF) ? 16'h0000 : PCT_MAX)
                            : fail_fixed_value;                                // [R10]
   wire [15:0] fail_value =
      (fail_sel_q == 2'(FAIL_FIXED)) ? fixed_fail  :
      (fail_sel_q == 2'(FAIL_MEAN))  ? mean_capped : 16'h0000;                 // [R6]
   wire [15:0] y_d = fail_mode ? fail_value : clamp(y_demand, y_lo_q, y_hi_q); // [R4]
   wire valve_cmd_t valve_d = aux_error ? valve_cmd_t'(aux_valve_q) : valve_demand; // [R5]

   logic [15:0] y_q;
   valve_cmd_t  valve_q;
   always_ff @(posedge sys_clk or negedge rst_sync_n) begin
      if (!rst_sync_n) begin
         y_q     <= 16'h0000;
         valve_q <= VALVE_HOLD;
      end else begin
         y_q     <= y_d;
         valve_q <= valve_d;
      end
   end

   assign reg_done            = done_q;
   assign reg_rdata           = rdata_q;
   assign reg_exc             = exc_q;
   assign y_out               = y_q;
   assign valve_cmd           = valve_q;
   assign mean_value          = mean_q;
   assign valve_open_time     = open_t_q;
   assign valve_close_time    = close_t_q;
   assign min_valve_work_time = min_work_q;

endmodule : controller_status_param_regs

/* ctl_regs_pkg.sv */
// Purpose: constants and carrier types for the controller parameter and status registers
// Assumes: one 16-bit holding-register word per address, 10 MHz system clock
// Notes:   control value figures are in tenths of a percent
//
// Summary of operation
// R1: valve open time held, 30..6000 tenths second
// R2: valve close time held, same range
// R3: minimum valve work time held, 1..999
// R4: control output clamped between lower/upper limits
// R5: aux input error drives valve close/open/hold
// R6: failure or stop selects off/fixed/mean output
// R7: mean updated each minute below deviation limit
// R8: failure mean value capped at upper limit
// R9: maximum tracking deviation held, 0..99999; the 16-bit register holds 0..65535
// R10: on-off failure output 0% or 100% by 50%
// R11: status bits 0-1 main decimal point, sensor 1
// R12: status bits 2-3 additional input decimal point
// R13: bit 4 tuning failed, bit 8 tuning active
// R14: bit 5 soft start active
// R15: bit 6 timer countdown finished
// R16: bit 7 manual mode flag
// R17: bits 9-10 active gain set number
// R18: bits 13/14 main/additional input out of range
// R19: bit 15 summary of any controller error
// R20: alarm word bits 0-2 alarms one to three
// R21: bit 4 heater burn-out, bit 5 output short
// R22: bit 6 digital input, bits 8-10 outputs
// R23: per-cause error register readable separately
// R24: no digital input fitted reads zero
// R25: reserved status bits read zero, writes ignored
package ctl_regs_pkg;

   localparam int unsigned CLK_HZ          = 10_000_000;
   localparam int unsigned MEAN_PERIOD_S   = 60;
   localparam int unsigned MEAN_CYCLES     = CLK_HZ * MEAN_PERIOD_S;

   localparam logic [15:0] ADDR_STATUS     = 16'h0fa3;
   localparam logic [15:0] ADDR_ALARM      = 16'h0fa4;
   localparam logic [15:0] ADDR_ERROR      = 16'h0fa5;
   localparam logic [15:0] ADDR_OPEN_T     = 16'h1014;
   localparam logic [15:0] ADDR_CLOSE_T    = 16'h1015;
   localparam logic [15:0] ADDR_MIN_WORK   = 16'h1016;
   localparam logic [15:0] ADDR_Y_LO       = 16'h1017;
   localparam logic [15:0] ADDR_Y_HI       = 16'h1018;
   localparam logic [15:0] ADDR_AUX_VALVE  = 16'h1019;
   localparam logic [15:0] ADDR_FAIL_SEL   = 16'h101a;
   localparam logic [15:0] ADDR_MEAN_HI    = 16'h101b;
   localparam logic [15:0] ADDR_MAX_DEV    = 16'h101c;

   localparam logic [15:0] TRAVEL_MIN      = 16'h001e;  // 30
   localparam logic [15:0] TRAVEL_MAX      = 16'h1770;  // 6000
   localparam logic [15:0] WORK_MIN        = 16'h0001;  // 1
   localparam logic [15:0] WORK_MAX        = 16'h03e7;  // 999
   localparam logic [15:0] PCT_MAX         = 16'h03e8;  // 1000 = 100.0 %
   localparam logic [15:0] PCT_HALF        = 16'h01f4;  // 500 = 50.0 %
   localparam logic [15:0] SEL_MAX         = 16'h0002;

   localparam logic [15:0] RST_OPEN_T      = 16'h0258;  // 60.0 s
   localparam logic [15:0] RST_CLOSE_T     = 16'h0258;
   localparam logic [15:0] RST_MIN_WORK    = 16'h0001;
   localparam logic [15:0] RST_Y_LO        = 16'h0000;
   localparam logic [15:0] RST_Y_HI        = 16'h03e8;
   localparam logic [15:0] RST_AUX_VALVE   = 16'h0002;
   localparam logic [15:0] RST_FAIL_SEL    = 16'h0000;
   localparam logic [15:0] RST_MEAN_HI     = 16'h03e8;
   localparam logic [15:0] RST_MAX_DEV     = 16'h0064;

   localparam logic [1:0]  SENSOR_DP       = 2'h1;
   localparam logic [15:0] ERROR_MASK      = 16'h800f;  // bits 0-3 and 15 defined

   localparam logic [7:0]  EXC_NONE        = 8'h00;
   localparam logic [7:0]  EXC_BAD_ADDR    = 8'h02;
   localparam logic [7:0]  EXC_BAD_VALUE   = 8'h03;

   typedef enum logic [1:0] {
      VALVE_CLOSE,
      VALVE_OPEN,
      VALVE_HOLD
   } valve_cmd_t;

   typedef enum logic [1:0] {
      FAIL_OFF,
      FAIL_FIXED,
      FAIL_MEAN
   } fail_sel_t;

   typedef struct packed {
      logic       sensor_input;
      logic [1:0] main_dp;
      logic [1:0] aux_dp;
      logic       tune_failed;
      logic       soft_start;
      logic       timer_done;
      logic       manual;
      logic       tune_active;
      logic [1:0] gain_set;
      logic       main_range_err;
      logic       aux_range_err;
   } ctl_status_t;

   typedef struct packed {
      logic [2:0] alarm;
      logic       heater_burnout;
      logic       output_short;
      logic [2:0] dig_out;
   } alarm_io_t;

endpackage : ctl_regs_pkg

/* controller_status_param_regs_chk.sv */
// Purpose: concurrent checks on the register port and the valve path
// Assumes: one clock domain, no strobe before the reset sync releases
// Notes:   bound to the top module after the checker
module controller_status_param_regs_chk
   import ctl_regs_pkg::*;
(
   input wire logic        sys_clk,        // clock
   input wire logic        rst_n,          // reset
   input wire logic        reg_wr,         // write
   input wire logic        reg_rd,         // read
   input wire logic [15:0] reg_addr,       // address
   input wire logic [15:0] reg_wdata,      // data in
   input wire logic [15:0] reg_rdata,      // data out
   input wire logic        reg_done,       // answer
   input wire logic [7:0]  reg_exc,        // exception
   input wire ctl_status_t status_in,      // status
   input wire alarm_io_t   alarm_in,       // alarms
   input wire logic [15:0] error_causes,   // errors
   input wire logic        aux_error,      // aux fault
   input wire valve_cmd_t  valve_demand,   // valve in
   input wire valve_cmd_t  valve_cmd,      // valve out
   input wire logic [15:0] valve_open_time // open time
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   wire logic strobe = reg_wr || reg_rd;
   wire logic ro_wr  = reg_wr && (reg_addr == ADDR_STATUS || reg_addr == ADDR_ALARM);

   a_answer_timely: assert property (strobe |=> reg_done)
      else $error("reg_done missing after strobe");
   a_answer_single: assert property (!strobe |=> !reg_done)
      else $error("reg_done without strobe");
   a_readonly_refused: assert property (ro_wr |=> reg_exc == EXC_BAD_ADDR)
      else $error("write to status word accepted");
   a_open_time_range: assert property (reg_wr && reg_addr == ADDR_OPEN_T &&
      (reg_wdata < TRAVEL_MIN || reg_wdata > TRAVEL_MAX)
      |=> reg_exc == EXC_BAD_VALUE && $stable(valve_open_time))
      else $error("bad open time taken");
   a_select_range: assert property (reg_wr && reg_addr == ADDR_FAIL_SEL &&
      reg_wdata > SEL_MAX |=> reg_exc == EXC_BAD_VALUE)
      else $error("bad failure select taken");
   a_valve_follow: assert property (!aux_error && $past(rst_n, 1) &&
      $past(rst_n, 2) && $past(rst_n, 3) |-> ##1 valve_cmd == $past(valve_demand))
      else $error("valve command does not follow demand");
   a_status_fields: assert property (reg_rd && reg_addr == ADDR_STATUS |=>
      reg_rdata[12:11] == 2'h0 && reg_rdata[15] == |$past(error_causes & ERROR_MASK) &&
      reg_rdata[10:7] == $past({status_in.gain_set, status_in.tune_active, status_in.manual}))
      else $error("status word fields wrong");
   a_alarm_fields: assert property (reg_rd && reg_addr == ADDR_ALARM |=>
      {reg_rdata[15:11], reg_rdata[7], reg_rdata[3]} == 7'h00 &&
      reg_rdata[10:8] == $past(alarm_in.dig_out) && reg_rdata[2:0] == $past(alarm_in.alarm))
      else $error("alarm word fields wrong");
endmodule : controller_status_param_regs_chk

bind controller_status_param_regs controller_status_param_regs_chk i_chk (
   .sys_clk(sys_clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_done(reg_done), .reg_exc(reg_exc),
   .status_in(status_in), .alarm_in(alarm_in), .error_causes(error_causes),
   .aux_error(aux_error), .valve_demand(valve_demand), .valve_cmd(valve_cmd),
   .valve_open_time(valve_open_time));

/* modbus_master_model.sv */
// Purpose: register-access master standing in for the serial-bus master
// Assumes: one strobe per access, answer within a few cycles
// Notes:   released address and data show the inverse of their last value
module modbus_master_model (
   input wire logic        sys_clk,   // clock
   input wire logic        reg_done,  // answer
   input wire logic [15:0] reg_rdata, // data out
   input wire logic [7:0]  reg_exc,   // exception
   output logic            reg_wr,    // write
   output logic            reg_rd,    // read
   output logic [15:0]     reg_addr,  // address
   output logic [15:0]     reg_wdata  // data in
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 16'h0000;
      reg_wdata = 16'h0000;
   end
   task automatic xfer(input logic w, input logic [15:0] a, input logic [15:0] d,
                       output logic [15:0] rd, output logic [7:0] ex);
      int n;
      n = 0;
      @(posedge sys_clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      #1;
      while (reg_done !== 1'b1 && n < 8) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      rd = reg_rdata;
      ex = (n < 8) ? reg_exc : 8'hff;
   endtask : xfer
endmodule : modbus_master_model

/* controller_status_param_regs_bench.sv */
// Purpose: self-checking bench for the controller parameter and status registers
// Assumes: mean tick shortened to 16 cycles
// Notes:   register traffic goes through the master model
module controller_status_param_regs_bench;
   import ctl_regs_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int TICK = 16;
   localparam logic [15:0] RA [9] = '{ADDR_OPEN_T, ADDR_CLOSE_T, ADDR_MIN_WORK, ADDR_Y_LO,
      ADDR_Y_HI, ADDR_AUX_VALVE, ADDR_FAIL_SEL, ADDR_MEAN_HI, ADDR_MAX_DEV};
   localparam logic [15:0] RV [9] = '{RST_OPEN_T, RST_CLOSE_T, RST_MIN_WORK, RST_Y_LO,
      RST_Y_HI, RST_AUX_VALVE, RST_FAIL_SEL, RST_MEAN_HI, RST_MAX_DEV};
   localparam logic [15:0] LO [9] = '{TRAVEL_MIN, TRAVEL_MIN, WORK_MIN, 16'h0, 16'h0,
      16'h0, 16'h0, 16'h0, 16'h0};
   localparam logic [15:0] HI [9] = '{TRAVEL_MAX, TRAVEL_MAX, WORK_MAX, PCT_MAX, PCT_MAX,
      SEL_MAX, SEL_MAX, PCT_MAX, 16'hffff};
   logic sys_clk, rst_n, reg_wr, reg_rd, reg_done, dig_in_pin, onoff_mode;
   logic sensor_fail, program_stop, aux_error;
   logic [15:0] reg_addr, reg_wdata, reg_rdata, error_causes, y_demand, fail_fixed_value;
   logic [15:0] y_out, mean_value;
   logic [7:0] reg_exc;
   logic [16:0] deviation_abs;
   ctl_status_t status_in;
   alarm_io_t alarm_in;
   valve_cmd_t valve_demand, valve_cmd;
   int bad_count;
   int checked;

   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   controller_status_param_regs #(.MEAN_TICK_CYCLES(TICK)) i_dut (.sys_clk(sys_clk),
      .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_done(reg_done), .reg_exc(reg_exc),
      .status_in(status_in), .alarm_in(alarm_in), .error_causes(error_causes),
      .dig_in_pin(dig_in_pin), .y_demand(y_demand), .onoff_mode(onoff_mode),
      .sensor_fail(sensor_fail), .program_stop(program_stop),
      .fail_fixed_value(fail_fixed_value), .deviation_abs(deviation_abs),
      .aux_error(aux_error), .valve_demand(valve_demand), .y_out(y_out),
      .valve_cmd(valve_cmd), .mean_value(mean_value), .valve_open_time(),
      .valve_close_time(), .min_valve_work_time());
   modbus_master_model i_master (.sys_clk(sys_clk), .reg_done(reg_done),
      .reg_rdata(reg_rdata), .reg_exc(reg_exc), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));

   task automatic chk16(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask : chk16

   task automatic acc(input logic w, input logic [15:0] a, input logic [15:0] d,
                      input logic [7:0] xe, input logic [15:0] re);
      logic [15:0] rd;
      logic [7:0] ex;
      i_master.xfer(w, a, d, rd, ex);
      chk16($sformatf("exc %h", a), {8'h00, xe}, {8'h00, ex});
      if (!w && xe === EXC_NONE) chk16($sformatf("rdata %h", a), re, rd);
   endtask : acc

   task automatic drive_y(input logic [15:0] yd, input logic [15:0] fx, input logic [15:0] e);
      @(posedge sys_clk);
      y_demand <= yd;
      fail_fixed_value <= fx;
      repeat (2) @(posedge sys_clk);
      #1;
      chk16("y_out", e, y_out);
   endtask : drive_y

   task automatic t_ranges;
      for (int i = 0; i < 9; i++) begin
         acc(1'b0, RA[i], 16'h0, EXC_NONE, RV[i]);
         acc(1'b1, RA[i], LO[i], EXC_NONE, 16'h0);
         acc(1'b0, RA[i], 16'h0, EXC_NONE, LO[i]);
         acc(1'b1, RA[i], HI[i], EXC_NONE, 16'h0);
         if (HI[i] != 16'hffff) acc(1'b1, RA[i], HI[i] + 16'h1, EXC_BAD_VALUE, 16'h0);
         if (LO[i] != 16'h0) acc(1'b1, RA[i], LO[i] - 16'h1, EXC_BAD_VALUE, 16'h0);
         acc(1'b0, RA[i], 16'h0, EXC_NONE, HI[i]);
         acc(1'b1, RA[i], RV[i], EXC_NONE, 16'h0);
      end
   endtask : t_ranges

   task automatic t_words;
      ctl_status_t s;
      alarm_io_t a;
      logic [15:0] e;
      for (int k = 0; k < 2; k++) begin
         s = (k == 0) ? 14'h2aaa : 14'h1555;
         e = (k == 0) ? 16'h0010 : 16'h8000;
         a = (k == 0) ? 8'ha5 : 8'h5a;
         @(posedge sys_clk);
         status_in <= s;
         error_causes <= e;
         alarm_in <= a;
         dig_in_pin <= (k == 0);
         repeat (4) @(posedge sys_clk);
         acc(1'b0, ADDR_STATUS, 16'h0, EXC_NONE, {|(e & ERROR_MASK), s.aux_range_err,
            s.main_range_err, 2'h0, s.gain_set, s.tune_active, s.manual, s.timer_done,
            s.soft_start, s.tune_failed, s.aux_dp, (s.sensor_input ? SENSOR_DP : s.main_dp)});
         acc(1'b0, ADDR_ALARM, 16'h0, EXC_NONE, {5'h00, a.dig_out, 1'b0, (k == 0),
            a.output_short, a.heater_burnout, 1'b0, a.alarm});
         acc(1'b0, ADDR_ERROR, 16'h0, EXC_NONE, e & ERROR_MASK);
      end
      acc(1'b1, ADDR_STATUS, 16'hffff, EXC_BAD_ADDR, 16'h0);
      acc(1'b1, ADDR_ALARM, 16'hffff, EXC_BAD_ADDR, 16'h0);
      acc(1'b0, 16'h1000, 16'h0, EXC_BAD_ADDR, 16'h0);
   endtask : t_words

   task automatic t_output;
      acc(1'b1, ADDR_Y_LO, 16'h0064, EXC_NONE, 16'h0);
      acc(1'b1, ADDR_Y_HI, 16'h0384, EXC_NONE, 16'h0);
      drive_y(16'h0032, 16'h012c, 16'h0064);
      drive_y(16'h03b6, 16'h012c, 16'h0384);
      sensor_fail <= 1'b1;
      drive_y(16'h01f4, 16'h012c, 16'h0000);
      acc(1'b1, ADDR_FAIL_SEL, 16'h0001, EXC_NONE, 16'h0);
      drive_y(16'h01f4, 16'h012c, 16'h012c);
      sensor_fail <= 1'b0;
      program_stop <= 1'b1;
      onoff_mode <= 1'b1;
      drive_y(16'h01f4, PCT_HALF, 16'h0000);
      drive_y(16'h01f4, PCT_HALF + 16'h1, PCT_MAX);
      program_stop <= 1'b0;
      onoff_mode <= 1'b0;
      deviation_abs <= 17'h00000;
      acc(1'b1, ADDR_Y_LO, RST_Y_LO, EXC_NONE, 16'h0);
      acc(1'b1, ADDR_Y_HI, RST_Y_HI, EXC_NONE, 16'h0);
      drive_y(16'h0320, 16'h0, 16'h0320);
      repeat (TICK * 14) @(posedge sys_clk);
      #1;
      chk16("mean", 16'h031f, mean_value);
      deviation_abs <= 17'h000c8;
      drive_y(16'h0000, 16'h0, 16'h0000);
      repeat (TICK * 3) @(posedge sys_clk);
      #1;
      chk16("mean", 16'h031f, mean_value);
      acc(1'b1, ADDR_MEAN_HI, 16'h01f4, EXC_NONE, 16'h0);
      acc(1'b1, ADDR_FAIL_SEL, 16'h0002, EXC_NONE, 16'h0);
      sensor_fail <= 1'b1;
      drive_y(16'h0000, 16'h0, 16'h01f4);
      acc(1'b1, ADDR_MEAN_HI, PCT_MAX, EXC_NONE, 16'h0);
      drive_y(16'h0000, 16'h0, 16'h031f);
      sensor_fail <= 1'b0;
   endtask : t_output

   task automatic t_valve;
      logic [1:0] e;
      for (int k = 0; k < 6; k++) begin
         if (k >= 3) acc(1'b1, ADDR_AUX_VALVE, 16'(k - 3), EXC_NONE, 16'h0);
         e = (k < 3) ? 2'(2 - k % 3) : 2'(k - 3);
         aux_error <= (k >= 3);
         valve_demand <= valve_cmd_t'(2 - k % 3);
         repeat (2) @(posedge sys_clk);
         #1;
         chk16("valve_cmd", {14'h0, e}, {14'h0, valve_cmd});
         @(posedge sys_clk);
      end
   endtask : t_valve

   task automatic summarize;
      $display("checks %0d errors %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : summarize

   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      summarize;
   end

   initial begin
      bad_count = 0;
      checked = 0;
      rst_n = 1'b0;
      status_in = '0;
      alarm_in = '0;
      error_causes = 16'h0000;
      dig_in_pin = 1'b0;
      y_demand = 16'h0000;
      onoff_mode = 1'b0;
      sensor_fail = 1'b0;
      program_stop = 1'b0;
      fail_fixed_value = 16'h0000;
      deviation_abs = 17'h1ffff;
      aux_error = 1'b0;
      valve_demand = VALVE_HOLD;
      repeat (10) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge sys_clk);
      t_ranges;
      t_words;
      t_output;
      t_valve;
      summarize;
   end
endmodule : controller_status_param_regs_bench
